// >>> shared/mlsc_cfg.svh
// Offsets, field positions, reset values and timing counts
`ifndef MLSC_CFG_SVH
`define MLSC_CFG_SVH
`define CLK_PERIOD_NS 10
`define RESET_PULSE_NS 10000
`define RESET_PULSE_CYC \
	((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_TIME_MS 2000
`define INIT_CYC (`INIT_TIME_MS * 64'd1000000 / `CLK_PERIOD_NS)
`define TARGET_ADDR 7'h50
`define AHB_CTRL 8'h00
`define AHB_STATUS 8'h04
`define AHB_LANE0 8'h08
`define AHB_LANE3 8'h14
`define CTRL_FAULT_BIT 0
`define MM_STATUS 4'h0
`define MM_LOSS 4'h1
`define MM_CTRL 4'h2
`define MM_LANE0 4'h3
`define CTRL_TXOFF_BIT 0
`define CTRL_LP_BIT 1
`define CTRL_RESET 2'h0
`endif

// >>> shared/mlsc_pkg.sv
// Types shared by the low-speed control block
package mlsc_pkg;
	typedef struct packed {
		logic sel_n;
		logic rst_n;
		logic lp;
		logic txoff;
		logic scl;
		logic sda;
		logic [3:0] loss;
	} pins_in_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
	} tws_state_t;
endpackage

// >>> rtl/module_low_speed_control.sv
// Low-speed management pins, 2-wire target and AHB-Lite register slave
// What this block does
// - Answer 2-wire traffic only while module select is low.
// - Reset pin held low past minimum pulse restores all defaults.
// - Reset completion pulls attention low with data-unready cleared.
// - Power-up posts the completion interrupt without a reset pulse.
// - Attention output driven low on fault or critical status.
// - Power limit set by low-power select pin, 2-wire control bit, or while not ready.
// - Presence line pulled to ground while inserted.
// - Transmitter off by pin, by 2-wire control bit, or both.
// - Loss alarm raised when any of four lanes is below threshold.
// - Per-lane optical power values readable over 2-wire.
// - All memory map accesses go over 2-wire, host initiated.
// - Full operation and reset-done interrupt within 2000 ms.
`include "mlsc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module module_low_speed_control #(
	parameter int unsigned INIT_CYCLES = 32'(`INIT_CYC),
	parameter int LANES = 4
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic module_select_n,
	input wire logic module_reset_n,
	input wire logic low_power_select,
	input wire logic transmit_off_pin,
	input wire logic [3:0] lane_below_threshold,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic attention_out,
	output logic attention_oe_n,
	output logic module_present_out,
	output logic module_present_oe_n,
	output logic transmit_off,
	output logic receive_signal_loss,
	output logic power_limit_low
);
	mlsc_pkg::pins_in_t pin_raw, s1_ff, s2_ff;
	logic scl_d_ff, sda_d_ff;
	logic scl_rise, scl_fall, tw_start, tw_stop;
	mlsc_pkg::tws_state_t st_ff, nxt_st;
	logic [3:0] bit_ff, nxt_bit, ptr_ff, nxt_ptr;
	logic [7:0] sh_ff, nxt_sh;
	logic first_ff, nxt_first, rw_ff, nxt_rw, nack_ff, nxt_nack;
	logic sda_low_ff, nxt_sda_low;
	logic [1:0] soft_ff, nxt_soft;
	logic notready_ff, nxt_notready, done_ff, nxt_done;
	logic fault_ff, nxt_fault, rd_status, load_byte;
	logic [31:0] init_cnt_ff, nxt_init_cnt;
	logic [9:0] rst_cnt_ff, nxt_rst_cnt;
	logic rst_hold_ff, nxt_rst_hold;
	logic [3:0] loss_prev_ff;
	logic txoff_ff, nxt_txoff, rxlos_ff, nxt_rxlos, lp_ff, nxt_lp;
	logic attn_oe_n_ff, nxt_attn_oe_n, zero_ff;
	logic [7:0] mm [16];
	logic [15:0] lane_ff [LANES];
	logic [15:0] nxt_lane [LANES];
	logic [7:0] wr_addr_ff, nxt_wr_addr;
	logic wr_pend_ff, nxt_wr_pend, fault_req_ff, nxt_fault_req;
	logic [31:0] rdata_ff, nxt_rdata;
	logic addr_phase;

	function automatic logic [31:0] ahb_read(input logic [7:0] a,
		input logic [31:0] stat, input logic [15:0] l0,
		input logic [15:0] l1, input logic [15:0] l2,
		input logic [15:0] l3);
		logic [31:0] r;
		r = 32'h0;
		unique case (a)
			`AHB_STATUS: r = stat;
			`AHB_LANE0: r = {16'h0, l0};
			`AHB_LANE0 + 8'h04: r = {16'h0, l1};
			`AHB_LANE0 + 8'h08: r = {16'h0, l2};
			`AHB_LANE3: r = {16'h0, l3};
			default: r = 32'h0;
		endcase
		return r;
	endfunction

	assign pin_raw = '{module_select_n, module_reset_n, low_power_select,
		transmit_off_pin, scl_in, sda_in, lane_below_threshold};

	// Two stages before any logic looks at a pin
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s1_ff <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0};
			s2_ff <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0};
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
			loss_prev_ff <= 4'h0;
			zero_ff <= 1'b0;
		end else if (clk_en) begin
			s1_ff <= pin_raw;
			s2_ff <= s1_ff;
			scl_d_ff <= s2_ff.scl;
			sda_d_ff <= s2_ff.sda;
			loss_prev_ff <= s2_ff.loss;
			zero_ff <= 1'b0;
		end
	end

	assign scl_rise = s2_ff.scl & ~scl_d_ff;
	assign scl_fall = ~s2_ff.scl & scl_d_ff;
	assign tw_start = scl_d_ff & s2_ff.scl & sda_d_ff & ~s2_ff.sda;
	assign tw_stop = scl_d_ff & s2_ff.scl & ~sda_d_ff & s2_ff.sda;

	// Memory map seen by the host; lane values come from firmware
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			mm[i] = 8'h00;
		end
		mm[`MM_STATUS] = {4'h0, |s2_ff.loss, fault_ff, done_ff, notready_ff};
		mm[`MM_LOSS] = {4'h0, s2_ff.loss};
		mm[`MM_CTRL] = {6'h0, soft_ff};
		for (int i = 0; i < LANES; i++) begin
			mm[`MM_LANE0 + 4'(2 * i)] = lane_ff[i][15:8];
			mm[`MM_LANE0 + 4'(2 * i + 1)] = lane_ff[i][7:0];
		end
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_bit = bit_ff;
		nxt_ptr = ptr_ff;
		nxt_sh = sh_ff;
		nxt_first = first_ff;
		nxt_rw = rw_ff;
		nxt_nack = nack_ff;
		nxt_sda_low = sda_low_ff;
		nxt_soft = soft_ff;
		load_byte = 1'b0;
		// Long reset pulse: count while low, hold defaults until release
		nxt_rst_cnt = s2_ff.rst_n ? 10'h0 : rst_cnt_ff;
		nxt_rst_hold = rst_hold_ff & ~s2_ff.rst_n;
		if (!s2_ff.rst_n && rst_cnt_ff < 10'(`RESET_PULSE_CYC)) begin
			nxt_rst_cnt = rst_cnt_ff + 10'h1;
		end else if (!s2_ff.rst_n) begin
			nxt_rst_hold = 1'b1;
		end
		if (rst_hold_ff || s2_ff.sel_n) begin
			nxt_st = mlsc_pkg::ST_IDLE;
			nxt_sda_low = 1'b0;
		end else if (tw_start) begin
			nxt_st = mlsc_pkg::ST_ADDR;
			nxt_bit = 4'h0;
			nxt_sda_low = 1'b0;
		end else if (tw_stop) begin
			nxt_st = mlsc_pkg::ST_IDLE;
			nxt_sda_low = 1'b0;
		end else if (scl_rise) begin
			unique case (st_ff)
				mlsc_pkg::ST_ADDR, mlsc_pkg::ST_WR: begin
					nxt_sh = {sh_ff[6:0], s2_ff.sda};
					nxt_bit = bit_ff + 4'h1;
				end
				mlsc_pkg::ST_RD_ACK: nxt_nack = s2_ff.sda;
				mlsc_pkg::ST_IDLE, mlsc_pkg::ST_ADDR_ACK, mlsc_pkg::ST_WR_ACK,
				mlsc_pkg::ST_RD: begin
				end
			endcase
		end else if (scl_fall) begin
			unique case (st_ff)
				mlsc_pkg::ST_ADDR: begin
					if (bit_ff == 4'h8 && sh_ff[7:1] == `TARGET_ADDR) begin
						nxt_st = mlsc_pkg::ST_ADDR_ACK;
						nxt_sda_low = 1'b1;
						nxt_rw = sh_ff[0];
						nxt_first = 1'b1;
					end else if (bit_ff == 4'h8) begin
						nxt_st = mlsc_pkg::ST_IDLE;
					end
				end
				mlsc_pkg::ST_ADDR_ACK: begin
					nxt_sda_low = 1'b0;
					nxt_bit = 4'h0;
					nxt_st = rw_ff ? mlsc_pkg::ST_RD : mlsc_pkg::ST_WR;
					load_byte = rw_ff;
				end
				mlsc_pkg::ST_WR: begin
					if (bit_ff == 4'h8) begin
						nxt_st = mlsc_pkg::ST_WR_ACK;
						nxt_sda_low = 1'b1;
						nxt_first = 1'b0;
						if (first_ff) begin
							nxt_ptr = sh_ff[3:0];
						end else begin
							nxt_ptr = ptr_ff + 4'h1;
						end
						if (!first_ff && ptr_ff == `MM_CTRL) begin
							nxt_soft = sh_ff[1:0];
						end
					end
				end
				mlsc_pkg::ST_WR_ACK: begin
					nxt_sda_low = 1'b0;
					nxt_bit = 4'h0;
					nxt_st = mlsc_pkg::ST_WR;
				end
				mlsc_pkg::ST_RD: begin
					if (bit_ff == 4'h7) begin
						nxt_st = mlsc_pkg::ST_RD_ACK;
						nxt_sda_low = 1'b0;
						nxt_ptr = ptr_ff + 4'h1;
					end else begin
						nxt_bit = bit_ff + 4'h1;
						nxt_sh = {sh_ff[6:0], 1'b0};
						nxt_sda_low = ~sh_ff[6];
					end
				end
				mlsc_pkg::ST_RD_ACK: begin
					// No acknowledge ends the read; the stop follows
					nxt_st = nack_ff ? mlsc_pkg::ST_IDLE : mlsc_pkg::ST_RD;
					nxt_bit = 4'h0;
					load_byte = ~nack_ff;
				end
				mlsc_pkg::ST_IDLE: begin
				end
			endcase
		end
		if (load_byte) begin
			nxt_sh = mm[ptr_ff];
			nxt_sda_low = ~mm[ptr_ff][7];
		end
		if (rst_hold_ff) begin
			nxt_soft = `CTRL_RESET;
			nxt_ptr = 4'h0;
		end
	end

	// Reading the status byte clears the sticky causes; a new event wins
	assign rd_status = load_byte & (ptr_ff == `MM_STATUS);

	always_comb begin
		nxt_init_cnt = init_cnt_ff;
		nxt_notready = notready_ff;
		nxt_done = done_ff & ~rd_status;
		nxt_fault = fault_ff & ~rd_status;
		if (rst_hold_ff) begin
			nxt_init_cnt = 32'h0;
			nxt_notready = 1'b1;
			nxt_done = 1'b0;
			nxt_fault = 1'b0;
		end else if (notready_ff) begin
			// Time-out fixed at the longest allowed start-up
			if (init_cnt_ff >= INIT_CYCLES - 32'h1) begin
				nxt_notready = 1'b0;
				nxt_done = 1'b1;
			end else begin
				nxt_init_cnt = init_cnt_ff + 32'h1;
			end
		end
		if (!rst_hold_ff && !notready_ff) begin
			if ((s2_ff.loss & ~loss_prev_ff) != 4'h0 || fault_req_ff) begin
				nxt_fault = 1'b1;
			end
		end
		nxt_attn_oe_n = ~(done_ff | fault_ff);
		nxt_txoff = s2_ff.txoff | soft_ff[`CTRL_TXOFF_BIT];
		nxt_rxlos = |s2_ff.loss;
		nxt_lp = s2_ff.lp | soft_ff[`CTRL_LP_BIT] | notready_ff;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			st_ff <= mlsc_pkg::ST_IDLE;
			bit_ff <= 4'h0;
			ptr_ff <= 4'h0;
			sh_ff <= 8'h00;
			first_ff <= 1'b0;
			rw_ff <= 1'b0;
			nack_ff <= 1'b0;
			sda_low_ff <= 1'b0;
			soft_ff <= `CTRL_RESET;
			rst_cnt_ff <= 10'h0;
			rst_hold_ff <= 1'b0;
			init_cnt_ff <= 32'h0;
			notready_ff <= 1'b1;
			done_ff <= 1'b0;
			fault_ff <= 1'b0;
			attn_oe_n_ff <= 1'b1;
			txoff_ff <= 1'b1;
			rxlos_ff <= 1'b0;
			lp_ff <= 1'b1;
		end else if (clk_en) begin
			st_ff <= nxt_st;
			bit_ff <= nxt_bit;
			ptr_ff <= nxt_ptr;
			sh_ff <= nxt_sh;
			first_ff <= nxt_first;
			rw_ff <= nxt_rw;
			nack_ff <= nxt_nack;
			sda_low_ff <= nxt_sda_low;
			soft_ff <= nxt_soft;
			rst_cnt_ff <= nxt_rst_cnt;
			rst_hold_ff <= nxt_rst_hold;
			init_cnt_ff <= nxt_init_cnt;
			notready_ff <= nxt_notready;
			done_ff <= nxt_done;
			fault_ff <= nxt_fault;
			attn_oe_n_ff <= nxt_attn_oe_n;
			txoff_ff <= nxt_txoff;
			rxlos_ff <= nxt_rxlos;
			lp_ff <= nxt_lp;
		end
	end

	// Zero-wait slave: read data registered in the address phase
	assign addr_phase = hsel & htrans[1] & hready;

	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			nxt_lane[i] = lane_ff[i];
			if (wr_pend_ff && wr_addr_ff == `AHB_LANE0 + 8'(4 * i)) begin
				nxt_lane[i] = hwdata[15:0];
			end
		end
		nxt_fault_req = wr_pend_ff & (wr_addr_ff == `AHB_CTRL) &
			hwdata[`CTRL_FAULT_BIT];
		nxt_wr_pend = addr_phase & hwrite;
		nxt_wr_addr = addr_phase ? {haddr[7:2], 2'b00} : wr_addr_ff;
		nxt_rdata = rdata_ff;
		if (addr_phase && !hwrite) begin
			nxt_rdata = ahb_read({haddr[7:2], 2'b00},
				{24'h0, s2_ff.loss, fault_ff, done_ff, rst_hold_ff,
				notready_ff}, lane_ff[0], lane_ff[1], lane_ff[2],
				lane_ff[3]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			for (int i = 0; i < LANES; i++) begin
				lane_ff[i] <= 16'h0000;
			end
			fault_req_ff <= 1'b0;
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			rdata_ff <= 32'h0;
		end else if (clk_en) begin
			lane_ff <= nxt_lane;
			fault_req_ff <= nxt_fault_req;
			wr_pend_ff <= nxt_wr_pend;
			wr_addr_ff <= nxt_wr_addr;
			rdata_ff <= nxt_rdata;
		end
	end

	assign hrdata = rdata_ff;
	assign hreadyout = ~zero_ff;
	assign hresp = zero_ff;
	assign sda_out = zero_ff;
	assign sda_oe_n = ~sda_low_ff;
	assign attention_out = zero_ff;
	assign attention_oe_n = attn_oe_n_ff;
	assign module_present_out = zero_ff;
	assign module_present_oe_n = zero_ff;
	assign transmit_off = txoff_ff;
	assign receive_signal_loss = rxlos_ff;
	assign power_limit_low = lp_ff;
endmodule
`default_nettype wire

// >>> tb/host_board_model.sv
// Host board model: 2-wire controller and line pull-ups
`timescale 1ns/10ps
`default_nettype none
module host_board_model (
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic att_out,
	input wire logic att_oe_n,
	input wire logic pres_out,
	input wire logic pres_oe_n,
	output var logic scl,
	output logic sda,
	output logic att_line,
	output logic pres_line
);
	logic drv_low = 1'b0;
	initial scl = 1'b1;
	// Released lines float up to the pull-ups
	assign sda = (drv_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;
	assign att_line = (!att_oe_n && !att_out) ? 1'b0 : 1'b1;
	assign pres_line = (!pres_oe_n && !pres_out) ? 1'b0 : 1'b1;
	task automatic bit_out(input logic v);
		#31 drv_low = !v;
		#31 scl = 1'b1;
		#63 scl = 1'b0;
	endtask
	task automatic bit_in(output logic v);
		#31 drv_low = 1'b0;
		#31 scl = 1'b1;
		v = sda;
		#63 scl = 1'b0;
	endtask
	// Late release leaves room for the target's ack hold
	task automatic start();
		#31 drv_low = 1'b0;
		#31 scl = 1'b1;
		#31 drv_low = 1'b1;
		#32 scl = 1'b0;
	endtask
	task automatic stop();
		#31 drv_low = 1'b1;
		#31 scl = 1'b1;
		#31 drv_low = 1'b0;
	endtask
	task automatic put(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_in(ack);
	endtask
	task automatic get(input logic nack, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_in(d[i]);
		end
		bit_out(nack);
	endtask
endmodule
`default_nettype wire

// >>> tb/module_low_speed_control_properties.sv
// Port checks for the low-speed control block
`timescale 1ns/10ps
`default_nettype none
module module_low_speed_control_properties #(
	parameter int unsigned INIT_CYCLES = 50
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic module_select_n,
	input wire logic module_reset_n,
	input wire logic low_power_select,
	input wire logic transmit_off_pin,
	input wire logic [3:0] lane_below_threshold,
	input wire logic sda_oe_n,
	input wire logic attention_oe_n,
	input wire logic module_present_out,
	input wire logic module_present_oe_n,
	input wire logic transmit_off,
	input wire logic receive_signal_loss,
	input wire logic power_limit_low
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	localparam int ATT_MAX = INIT_CYCLES + 8;
	logic [10:0] mr_cnt_ff;
	logic ctl_wr_ff;
	// Saturates so a long hold never wraps
	always_ff @(posedge core_clk) begin
		if (!resetn || module_reset_n) begin
			mr_cnt_ff <= 11'h0;
		end else if (mr_cnt_ff != 11'h7ff) begin
			mr_cnt_ff <= mr_cnt_ff + 11'h1;
		end
	end
	always_ff @(posedge core_clk) begin
		ctl_wr_ff <= hsel && htrans[1] && hwrite && haddr == 32'h0;
	end
	property p_sel_off;
		module_select_n [*6] |-> sda_oe_n;
	endproperty
	a_sel_off: assert property (p_sel_off)
		else $error("sda driven unselected");
	property p_mrst;
		mr_cnt_ff > 11'h3fc |-> power_limit_low && sda_oe_n;
	endproperty
	a_mrst: assert property (p_mrst)
		else $error("defaults not held");
	property p_att_quiet;
		$rose(resetn) |-> attention_oe_n [*8];
	endproperty
	a_att_quiet: assert property (p_att_quiet)
		else $error("attention early");
	property p_att_done;
		$rose(resetn) |-> ##[1:ATT_MAX] !attention_oe_n;
	endproperty
	a_att_done: assert property (p_att_done)
		else $error("no completion attention");
	property p_fault;
		ctl_wr_ff && hwdata[0] |-> ##[1:4] !attention_oe_n;
	endproperty
	a_fault: assert property (p_fault)
		else $error("fault without attention");
	property p_power;
		low_power_select [*6] |-> power_limit_low;
	endproperty
	a_power: assert property (p_power)
		else $error("power not limited");
	property p_present;
		!module_present_out && !module_present_oe_n;
	endproperty
	a_present: assert property (p_present)
		else $error("presence released");
	property p_txoff;
		transmit_off_pin [*6] |-> transmit_off;
	endproperty
	a_txoff: assert property (p_txoff)
		else $error("transmitter on");
	property p_loss_on;
		(|lane_below_threshold) [*5] |-> receive_signal_loss;
	endproperty
	a_loss_on: assert property (p_loss_on)
		else $error("loss alarm missing");
	property p_loss_off;
		(lane_below_threshold == 4'h0) [*5] |-> !receive_signal_loss;
	endproperty
	a_loss_off: assert property (p_loss_off)
		else $error("loss alarm stuck");
endmodule
bind module_low_speed_control module_low_speed_control_properties #(
	.INIT_CYCLES(INIT_CYCLES)) u_props (.core_clk(core_clk),
	.resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .module_select_n(module_select_n),
	.module_reset_n(module_reset_n), .low_power_select(low_power_select),
	.transmit_off_pin(transmit_off_pin),
	.lane_below_threshold(lane_below_threshold), .sda_oe_n(sda_oe_n),
	.attention_oe_n(attention_oe_n), .module_present_out(module_present_out),
	.module_present_oe_n(module_present_oe_n), .transmit_off(transmit_off),
	.receive_signal_loss(receive_signal_loss),
	.power_limit_low(power_limit_low));
`default_nettype wire

// >>> tb/module_low_speed_control_tb_top.sv
// Self-checking bench for the low-speed control block
`include "mlsc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module module_low_speed_control_tb_top;
	logic core_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic sel_n = 1'b0;
	logic mrst_n = 1'b1, lp = 1'b0, txp = 1'b0;
	logic [3:0] lanes = 4'h0;
	logic hreadyout, hresp, sda_out, sda_oe_n, att_out, att_oe_n, pres_out;
	logic pres_oe_n, transmit_off, rx_loss, plim, scl, sda, att, pres, a;
	logic [7:0] b;
	int mismatches = 0, compares = 0;
	always #5 core_clk = !core_clk;
	module_low_speed_control #(.INIT_CYCLES(50)) u_dut (.core_clk(core_clk),
		.resetn(resetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .module_select_n(sel_n), .module_reset_n(mrst_n),
		.low_power_select(lp), .transmit_off_pin(txp),
		.lane_below_threshold(lanes), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .attention_out(att_out),
		.attention_oe_n(att_oe_n), .module_present_out(pres_out),
		.module_present_oe_n(pres_oe_n), .transmit_off(transmit_off),
		.receive_signal_loss(rx_loss), .power_limit_low(plim));
	host_board_model u_host (.sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.att_out(att_out), .att_oe_n(att_oe_n), .pres_out(pres_out),
		.pres_oe_n(pres_oe_n), .scl(scl), .sda(sda), .att_line(att),
		.pres_line(pres));
	task automatic chk(input logic [31:0] s, e);
		#1;
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic ahb(input logic w, input logic [31:0] ad, d);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= ad;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wait_att();
		int n;
		n = 0;
		while (att !== 1'b0 && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		chk(att, 0);
	endtask
	task automatic i2c_wr(input logic [7:0] p, d);
		u_host.start();
		u_host.put({`TARGET_ADDR, 1'b0}, a);
		chk(a, 0);
		u_host.put(p, a);
		u_host.put(d, a);
		u_host.stop();
	endtask
	task automatic i2c_rd(input logic [7:0] p, e);
		u_host.start();
		u_host.put({`TARGET_ADDR, 1'b0}, a);
		u_host.put(p, a);
		u_host.start();
		u_host.put({`TARGET_ADDR, 1'b1}, a);
		u_host.get(1'b1, b);
		u_host.stop();
		chk(b, e);
	endtask
	task automatic t_init();
		chk(pres, 0);
		chk(att, 1);
		wait_att();
		ahb(1'b0, `AHB_STATUS, 0);
		chk(r[2:0], 3'h4);
		ahb(1'b0, 32'h40, 0);
		chk(r, 0);
		i2c_rd(`MM_STATUS, 8'h02);
		chk(att, 1);
		$display("t_init done");
	endtask
	task automatic t_unsel();
		sel_n <= 1'b1;
		cyc(4);
		u_host.start();
		u_host.put({`TARGET_ADDR, 1'b0}, a);
		u_host.stop();
		chk(a, 1);
		sel_n <= 1'b0;
		cyc(4);
		$display("t_unsel done");
	endtask
	task automatic t_ctrl();
		for (int v = 0; v < 16; v++) begin
			i2c_wr(`MM_CTRL, {6'h0, v[1:0]});
			@(posedge core_clk);
			{lp, txp} <= v[3:2];
			cyc(6);
			chk(transmit_off, v[0] | v[2]);
			chk(plim, v[1] | v[3]);
		end
		{lp, txp} <= 2'h0;
		i2c_rd(`MM_CTRL, 8'h03);
		$display("t_ctrl done");
	endtask
	task automatic t_lanes();
		for (int n = 0; n < 4; n++) begin
			ahb(1'b1, `AHB_LANE0 + 4 * n, 32'ha50 + n);
			i2c_rd(8'(`MM_LANE0 + 2 * n), 8'h0a);
			i2c_rd(8'(`MM_LANE0 + 2 * n + 1), 8'(8'h50 + n));
		end
		$display("t_lanes done");
	endtask
	task automatic t_loss();
		for (int i = 0; i < 4; i++) begin
			lanes <= 4'h1 << i;
			cyc(5);
			chk(rx_loss, 1);
			ahb(1'b0, `AHB_STATUS, 0);
			chk(r[7:3], {4'h1 << i, 1'b1});
			if (i == 3) begin
				i2c_rd(`MM_LOSS, 8'h08);
			end
			lanes <= 4'h0;
			cyc(5);
			chk(rx_loss, 0);
		end
		chk(att, 0);
		i2c_rd(`MM_STATUS, 8'h04);
		chk(att, 1);
		ahb(1'b1, `AHB_CTRL, 1);
		cyc(4);
		chk(att, 0);
		i2c_rd(`MM_STATUS, 8'h04);
		$display("t_loss done");
	endtask
	task automatic t_mreset();
		mrst_n <= 1'b0;
		cyc(1100);
		chk(plim, 1);
		mrst_n <= 1'b1;
		cyc(4);
		wait_att();
		chk(transmit_off, 0);
		i2c_rd(`MM_CTRL, 8'h00);
		i2c_rd(`MM_STATUS, 8'h02);
		$display("t_mreset done");
	endtask
	task automatic report_and_stop();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		cyc(3);
		resetn <= 1'b1;
		t_init();
		t_unsel();
		t_ctrl();
		t_lanes();
		t_loss();
		t_mreset();
		report_and_stop();
	end
	// Nearly three times the expected run
	initial begin
		#400000;
		mismatches++;
		report_and_stop();
	end
endmodule
`default_nettype wire
